// File: design/port_phy_status_loopback_regs.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module port_phy_status_loopback_regs
(
   input  wire logic       CLOCK,             // core clock, 10 MHz
   input  wire logic       RESET_N,           // async reset, low
   input  wire logic [7:0] REG_ADDR,          // switch register address
   input  wire logic [7:0] REG_WDATA,         // switch register write data
   input  wire logic       REG_WE,            // write strobe
   input  wire logic       REG_RE,            // read strobe
   output logic      [7:0] REG_RDATA,         // read data
   output logic            REG_RVALID,        // read data valid pulse
   input  wire logic       MIIM_PORT,         // 0 port 1, 1 port 2
   input  wire logic [4:0] MIIM_REG,          // management register number
   input  wire logic [15:0] MIIM_WDATA,       // management write data
   input  wire logic       MIIM_WE,           // management write strobe
   input  wire logic       MIIM_RE,           // management read strobe
   output logic     [15:0] MIIM_RDATA,        // management read data
   output logic            MIIM_RVALID,       // management read valid pulse
   input  wire logic [9:0] PARTNER_ABILITY,   // 5 bits per port
   input  wire logic [1:0] CROSSOVER_STATE,   // 1 mdi, 0 mdi-x
   input  wire logic [1:0] AUTONEG_COMPLETE,  // negotiation finished
   input  wire logic [1:0] LINK_GOOD,         // link up
   input  wire logic [1:0] SPEED_100,         // resolved 100 Mb/s
   input  wire logic [1:0] FULL_DUPLEX,       // resolved full duplex
   input  wire logic [7:0] MAC_TXD,           // switch transmit nibbles
   input  wire logic [1:0] MAC_TX_EN,         // switch transmit enables
   input  wire logic [7:0] PMA_RXD,           // phy receive nibbles
   input  wire logic [1:0] PMA_RX_DV,         // phy receive valid
   output logic      [7:0] PMA_TXD,           // phy transmit nibbles
   output logic      [1:0] PMA_TX_EN,         // phy transmit enables
   output logic      [7:0] MAC_RXD,           // switch receive nibbles
   output logic      [1:0] MAC_RX_DV,         // switch receive valid
   output logic      [1:0] MEDIUM_SIDE_LOOP_ENABLE, // pma loop command
   output logic      [1:0] PHY_ISOLATE,       // phy isolation command
   output logic      [1:0] TX_LINE_EN         // transmit line driver enable
);

   // ---------------------------------------------------------------
   // per port banks
   // ---------------------------------------------------------------
   logic [7:0] status1 [2];  // partner status bytes
   logic [7:0] status2 [2];  // control/mode bytes
   logic [1:0] loop_en;      // loop bits
   logic [1:0] isolate;      // isolate bits
   logic [1:0] bus_we;       // per port bus write
   logic [1:0] mii_we;       // per port management write

   // write decode, if chain on address
   always_comb
   begin
      bus_we = 2'b00;
      if (REG_WE && REG_ADDR == port_phy_pkg::OFS_P1_LOOP_CTRL)
         bus_we = 2'b01;
      else if (REG_WE && REG_ADDR == port_phy_pkg::OFS_P2_LOOP_CTRL)
         bus_we = 2'b10;
      mii_we = 2'b00;
      if (MIIM_WE && MIIM_REG == port_phy_pkg::MII_REG_CONTROL)
         mii_we = MIIM_PORT ? 2'b10 : 2'b01;
   end

   port_phy_bank u_bank1
   (
      .clock            (CLOCK),
      .reset_n          (RESET_N),
      .bus_we           (bus_we[0]),
      .bus_wdata        (REG_WDATA),
      .mii_we           (mii_we[0]),
      .mii_loop         (MIIM_WDATA[port_phy_pkg::MII_BIT_LOOP]),
      .mii_iso          (MIIM_WDATA[port_phy_pkg::MII_BIT_ISOLATE]),
      .partner_ability  (PARTNER_ABILITY[4:0]),
      .crossover_state  (CROSSOVER_STATE[0]),
      .autoneg_complete (AUTONEG_COMPLETE[0]),
      .link_good        (LINK_GOOD[0]),
      .speed_100        (SPEED_100[0]),
      .full_duplex      (FULL_DUPLEX[0]),
      .status1          (status1[0]),
      .status2          (status2[0]),
      .loop_en          (loop_en[0]),
      .isolate          (isolate[0])
   );

   port_phy_bank u_bank2
   (
      .clock            (CLOCK),
      .reset_n          (RESET_N),
      .bus_we           (bus_we[1]),
      .bus_wdata        (REG_WDATA),
      .mii_we           (mii_we[1]),
      .mii_loop         (MIIM_WDATA[port_phy_pkg::MII_BIT_LOOP]),
      .mii_iso          (MIIM_WDATA[port_phy_pkg::MII_BIT_ISOLATE]),
      .partner_ability  (PARTNER_ABILITY[9:5]),
      .crossover_state  (CROSSOVER_STATE[1]),
      .autoneg_complete (AUTONEG_COMPLETE[1]),
      .link_good        (LINK_GOOD[1]),
      .speed_100        (SPEED_100[1]),
      .full_duplex      (FULL_DUPLEX[1]),
      .status1          (status1[1]),
      .status2          (status2[1]),
      .loop_en          (loop_en[1]),
      .isolate          (isolate[1])
   );

   // ---------------------------------------------------------------
   // switch register read port
   // ---------------------------------------------------------------
   logic [7:0] next_reg_rdata;  // next read data

   // read decode, unmapped reads return zero
   always_comb
   begin
      next_reg_rdata = 8'h00;
      if (REG_RE && REG_ADDR == port_phy_pkg::OFS_P1_PARTNER_STATUS)
         next_reg_rdata = status1[0];
      else if (REG_RE && REG_ADDR == port_phy_pkg::OFS_P1_LOOP_CTRL)
         next_reg_rdata = status2[0];
      else if (REG_RE && REG_ADDR == port_phy_pkg::OFS_P2_PARTNER_STATUS)
         next_reg_rdata = status1[1];
      else if (REG_RE && REG_ADDR == port_phy_pkg::OFS_P2_LOOP_CTRL)
         next_reg_rdata = status2[1];
   end

   // read data register
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         REG_RDATA  <= 8'h00;
         REG_RVALID <= 1'b0;
      end
      else
      begin
         REG_RDATA  <= next_reg_rdata;
         REG_RVALID <= REG_RE;
      end
   end

   // ---------------------------------------------------------------
   // management register read port
   // ---------------------------------------------------------------
   logic [15:0] next_miim_rdata;  // next management read data
   logic [7:0]  sel_s1;           // selected port status byte
   logic [1:0]  sel_ctl;          // selected loop and isolate

   // map port bytes onto the standard register layout
   always_comb
   begin
      sel_s1          = MIIM_PORT ? status1[1] : status1[0];
      sel_ctl         = MIIM_PORT ? {loop_en[1], isolate[1]} : {loop_en[0], isolate[0]};
      next_miim_rdata = 16'h0000;
      if (MIIM_RE && MIIM_REG == port_phy_pkg::MII_REG_CONTROL)
      begin
         next_miim_rdata[port_phy_pkg::MII_BIT_LOOP]    = sel_ctl[1];
         next_miim_rdata[port_phy_pkg::MII_BIT_ISOLATE] = sel_ctl[0];
      end
      else if (MIIM_RE && MIIM_REG == port_phy_pkg::MII_REG_STATUS)
      begin
         next_miim_rdata[port_phy_pkg::MII_BIT_AUTONEG_COMPLETE] = sel_s1[port_phy_pkg::BIT_AN_COMPLETE];
         next_miim_rdata[port_phy_pkg::MII_BIT_LINK]    = sel_s1[port_phy_pkg::BIT_LINK_GOOD];
      end
      else if (MIIM_RE && MIIM_REG == port_phy_pkg::MII_REG_PARTNER)
      begin
         next_miim_rdata[port_phy_pkg::MII_BIT_PAUSE] = sel_s1[port_phy_pkg::BIT_PAUSE];
         next_miim_rdata[port_phy_pkg::MII_BIT_100FD] = sel_s1[port_phy_pkg::BIT_100FD];
         next_miim_rdata[port_phy_pkg::MII_BIT_100HD] = sel_s1[port_phy_pkg::BIT_100HD];
         next_miim_rdata[port_phy_pkg::MII_BIT_10FD]  = sel_s1[port_phy_pkg::BIT_10FD];
         next_miim_rdata[port_phy_pkg::MII_BIT_10HD]  = sel_s1[port_phy_pkg::BIT_10HD];
      end
   end

   // management read register
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         MIIM_RDATA  <= 16'h0000;
         MIIM_RVALID <= 1'b0;
      end
      else
      begin
         MIIM_RDATA  <= next_miim_rdata;
         MIIM_RVALID <= MIIM_RE;
      end
   end

   // ---------------------------------------------------------------
   // loop and isolation data path
   // ---------------------------------------------------------------
   logic [7:0] next_pma_txd;    // next phy transmit data
   logic [1:0] next_pma_tx_en;  // next phy transmit enable
   logic [7:0] next_mac_rxd;    // next switch receive data
   logic [1:0] next_mac_rx_dv;  // next switch receive valid

   // route each port: looped, monitor, isolated or normal
   always_comb
   begin
      next_pma_txd   = 8'h00;
      next_pma_tx_en = 2'b00;
      next_mac_rxd   = 8'h00;
      next_mac_rx_dv = 2'b00;
      for (int p = 0; p < 2; p++)
      begin
         if (isolate[p])
         begin
            next_pma_tx_en[p] = 1'b0;
         end
         else if (loop_en[p])
         begin
            // monitor receive feeds the looped phy
            next_pma_txd[4*p +: 4] = PMA_RXD[4*(1-p) +: 4];
            next_pma_tx_en[p]      = PMA_RX_DV[1-p];
         end
         else if (loop_en[1-p])
         begin
            // looped phy returns out the monitor port
            next_pma_txd[4*p +: 4] = PMA_RXD[4*(1-p) +: 4];
            next_pma_tx_en[p]      = PMA_RX_DV[1-p];
         end
         else
         begin
            next_pma_txd[4*p +: 4] = MAC_TXD[4*p +: 4];
            next_pma_tx_en[p]      = MAC_TX_EN[p];
            next_mac_rxd[4*p +: 4] = PMA_RXD[4*p +: 4];
            next_mac_rx_dv[p]      = PMA_RX_DV[p];
         end
      end
   end

   // data path and phy command registers
   always_ff @(posedge CLOCK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         PMA_TXD                 <= 8'h00;
         PMA_TX_EN               <= 2'b00;
         MAC_RXD                 <= 8'h00;
         MAC_RX_DV               <= 2'b00;
         MEDIUM_SIDE_LOOP_ENABLE <= 2'b00;
         PHY_ISOLATE             <= 2'b00;
         TX_LINE_EN              <= 2'b00;
      end
      else
      begin
         PMA_TXD                 <= next_pma_txd;
         PMA_TX_EN               <= next_pma_tx_en;
         MAC_RXD                 <= next_mac_rxd;
         MAC_RX_DV               <= next_mac_rx_dv;
         MEDIUM_SIDE_LOOP_ENABLE <= loop_en & ~isolate;
         PHY_ISOLATE             <= isolate;
         TX_LINE_EN              <= ~isolate;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_LOOP_WRITE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      REG_WE && REG_ADDR == 8'h2f && !REG_WDATA[5] |=> ##1
      MEDIUM_SIDE_LOOP_ENABLE[0] == $past(REG_WDATA[7], 2))
      else $error("port 1 loop write not applied");
   AST_ISOLATE_LINE: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      PHY_ISOLATE[1] |-> !TX_LINE_EN[1] && !PMA_TX_EN[1])
      else $error("isolated port still drives line");
   AST_MONITOR_PATH: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      loop_en[0] && !isolate[0] && !isolate[1] |=>
      PMA_TXD[7:4] == $past(PMA_RXD[3:0]) && MAC_RX_DV[1] == 1'b0)
      else $error("monitor port does not return looped data");
   AST_STATUS_READ: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      REG_RE && REG_ADDR == 8'h3e |=> REG_RVALID && REG_RDATA == $past(status1[1]))
      else $error("port 2 status read wrong");
   AST_RESERVED_ZERO: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      REG_RE && REG_ADDR == 8'h2f |=> REG_RDATA[6] == 1'b0)
      else $error("reserved bit read nonzero");
   AST_MIIM_LINK: assert property (@(posedge CLOCK) disable iff (!RESET_N)
      MIIM_RE && MIIM_REG == 5'h01 && !MIIM_PORT |=>
      MIIM_RDATA[2] == $past(status1[0][5]))
      else $error("management link bit wrong");

endmodule // port_phy_status_loopback_regs

// File: design/port_phy_pkg.sv
package port_phy_pkg;

   // ---------------------------------------------------------------
   // switch register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_P1_PARTNER_STATUS = 8'h2e;  // port 1 status 1
   localparam logic [7:0] OFS_P1_LOOP_CTRL      = 8'h2f;  // port 1 control 7 / status 2
   localparam logic [7:0] OFS_P2_PARTNER_STATUS = 8'h3e;  // port 2 status 1
   localparam logic [7:0] OFS_P2_LOOP_CTRL      = 8'h3f;  // port 2 control 7 / status 2

   // ---------------------------------------------------------------
   // partner status field positions
   // ---------------------------------------------------------------
   localparam int BIT_CROSSOVER   = 7;  // 1 mdi, 0 mdi-x
   localparam int BIT_AN_COMPLETE = 6;  // autoneg complete
   localparam int BIT_LINK_GOOD   = 5;  // link good
   localparam int BIT_PAUSE       = 4;  // partner pause ability
   localparam int BIT_100FD       = 3;  // partner 100 full
   localparam int BIT_100HD       = 2;  // partner 100 half
   localparam int BIT_10FD        = 1;  // partner 10 full
   localparam int BIT_10HD        = 0;  // partner 10 half

   // ---------------------------------------------------------------
   // loop control / mode status field positions
   // ---------------------------------------------------------------
   localparam int BIT_LOOP     = 7;  // medium side loop enable
   localparam int BIT_RESERVED = 6;  // reserved, reads zero
   localparam int BIT_ISOLATE  = 5;  // phy isolation
   localparam int MODE_MSB     = 2;  // mode field top bit

   // ---------------------------------------------------------------
   // operating mode codes and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] MODE_AN_BUSY = 3'h1;  // still negotiating
   localparam logic [2:0] MODE_10_HALF = 3'h2;
   localparam logic [2:0] MODE_100_HALF = 3'h3;
   localparam logic [2:0] MODE_10_FULL = 3'h5;
   localparam logic [2:0] MODE_100_FULL = 3'h6;
   localparam logic [7:0] RST_STATUS1  = 8'h00;
   localparam logic       RST_LOOP     = 1'b0;
   localparam logic       RST_ISOLATE  = 1'b0;
   localparam logic [2:0] RST_MODE     = MODE_AN_BUSY;

   // ---------------------------------------------------------------
   // management serial register set mapping
   // ---------------------------------------------------------------
   localparam logic [4:0] MII_REG_CONTROL = 5'h00;  // basic control
   localparam logic [4:0] MII_REG_STATUS  = 5'h01;  // basic status
   localparam logic [4:0] MII_REG_PARTNER = 5'h05;  // partner ability
   localparam int MII_BIT_LOOP    = 14;
   localparam int MII_BIT_ISOLATE = 10;
   localparam int MII_BIT_AUTONEG_COMPLETE = 5;
   localparam int MII_BIT_LINK    = 2;
   localparam int MII_BIT_PAUSE   = 10;
   localparam int MII_BIT_100FD   = 8;
   localparam int MII_BIT_100HD   = 7;
   localparam int MII_BIT_10FD    = 6;
   localparam int MII_BIT_10HD    = 5;

endpackage

// File: design/port_phy_bank.sv
`timescale 1ns/100ps
// one port's status and loop control registers
module port_phy_bank
(
   input  wire logic       clock,            // core clock
   input  wire logic       reset_n,          // async reset, low
   input  wire logic       bus_we,           // switch bus write to control
   input  wire logic [7:0] bus_wdata,        // switch bus write data
   input  wire logic       mii_we,           // management write to control
   input  wire logic       mii_loop,         // management loop value
   input  wire logic       mii_iso,          // management isolate value
   input  wire logic [4:0] partner_ability,  // pause,100fd,100hd,10fd,10hd
   input  wire logic       crossover_state,  // resolved crossover
   input  wire logic       autoneg_complete, // negotiation finished
   input  wire logic       link_good,        // link up
   input  wire logic       speed_100,        // resolved speed
   input  wire logic       full_duplex,      // resolved duplex
   output logic [7:0]      status1,          // partner status byte
   output logic [7:0]      status2,          // control/mode byte
   output logic            loop_en,          // medium side loop enable
   output logic            isolate           // phy isolation
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [7:0] next_status1;  // next status byte
   logic [2:0] mode;          // resolved mode code
   logic [2:0] next_mode;     // next mode code
   logic       next_loop_en;  // next loop bit
   logic       next_isolate;  // next isolate bit

   // status capture and mode encoding
   always_comb
   begin
      next_status1 = {crossover_state, autoneg_complete, link_good,
                      partner_ability};
      if (!autoneg_complete)
         next_mode = port_phy_pkg::MODE_AN_BUSY;
      else if (speed_100 && full_duplex)
         next_mode = port_phy_pkg::MODE_100_FULL;
      else if (speed_100)
         next_mode = port_phy_pkg::MODE_100_HALF;
      else if (full_duplex)
         next_mode = port_phy_pkg::MODE_10_FULL;
      else
         next_mode = port_phy_pkg::MODE_10_HALF;
   end

   // control bits: switch bus first, management path second
   always_comb
   begin
      next_loop_en = loop_en;
      next_isolate = isolate;
      if (bus_we)
      begin
         next_loop_en = bus_wdata[port_phy_pkg::BIT_LOOP];
         next_isolate = bus_wdata[port_phy_pkg::BIT_ISOLATE];
      end
      else if (mii_we)
      begin
         next_loop_en = mii_loop;
         next_isolate = mii_iso;
      end
   end

   // register stage
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status1 <= port_phy_pkg::RST_STATUS1;
         mode    <= port_phy_pkg::RST_MODE;
         loop_en <= port_phy_pkg::RST_LOOP;
         isolate <= port_phy_pkg::RST_ISOLATE;
      end
      else
      begin
         status1 <= next_status1;
         mode    <= next_mode;
         loop_en <= next_loop_en;
         isolate <= next_isolate;
      end
   end

   // reserved bits read zero, rule: bits 4..3 unused
   assign status2 = {loop_en, 1'b0, isolate, 2'b00, mode};

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_MODE_BUSY: assert property (@(posedge clock) disable iff (!reset_n)
      !autoneg_complete |=> mode == port_phy_pkg::MODE_AN_BUSY)
      else $error("mode not busy while negotiating");
   AST_MODE_LEGAL: assert property (@(posedge clock) disable iff (!reset_n)
      mode != 3'h0 && mode != 3'h4 && mode != 3'h7)
      else $error("reserved mode code reported");
   AST_MODE_100FD: assert property (@(posedge clock) disable iff (!reset_n)
      autoneg_complete && speed_100 && full_duplex |=> mode == 3'h6)
      else $error("100 full mode code wrong");
   AST_PARTNER_BITS: assert property (@(posedge clock) disable iff (!reset_n)
      1'b1 |=> status1[4:0] == $past(partner_ability))
      else $error("partner ability bits wrong");

endmodule // port_phy_bank

// File: dv/link_partner_model.sv
`timescale 1ns/100ps
// -------------------------------------------------------------
// link partner: negotiates after start, then streams nibbles
// -------------------------------------------------------------
module link_partner_model
#(
   parameter logic [4:0] ABILITY   = 5'h1f, // advertised abilities
   parameter logic       MDI       = 1'b1,  // crossover result
   parameter logic [3:0] SEED      = 4'h0,  // pattern value at reset, keeps two ports apart
   parameter int         AN_CYCLES = 20     // negotiation length
)
(
   input  wire logic       clock,            // core clock
   input  wire logic       reset_n,          // async reset, low
   input  wire logic       start,            // begin negotiation
   output logic      [4:0] ability,          // abilities once negotiated
   output logic            crossover_state,  // MDI once negotiated, else 0
   output logic            autoneg_complete, // negotiation finished
   output logic            link_good,        // link up
   output logic      [3:0] rxd,              // receive nibble
   output logic            rx_dv             // receive valid
);
   int         cnt; // cycles since start, stops at AN_CYCLES
   logic [3:0] pat; // changes every cycle so stale data shows
   // negotiation timer and stream pattern
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt <= 0;
         pat <= SEED;
      end
      else
      begin
         pat <= pat + 4'h3;
         if (start && cnt < AN_CYCLES)
            cnt <= cnt + 1;
      end
   end
   // nothing is known of the partner until negotiation ends
   assign autoneg_complete = (cnt >= AN_CYCLES);
   assign link_good        = autoneg_complete;
   assign ability          = autoneg_complete ? ABILITY : 5'h00;
   assign crossover_state  = autoneg_complete & MDI;
   assign rxd              = autoneg_complete ? pat : ~pat; // idle line toggles
   assign rx_dv            = autoneg_complete;
endmodule // link_partner_model

// File: dv/port_phy_status_loopback_regs_bench.sv
`timescale 1ns/100ps
module port_phy_status_loopback_regs_bench;
   logic CLOCK = 1'b0, RESET_N = 1'b0, REG_WE = 1'b0, REG_RE = 1'b0, MIIM_PORT = 1'b0;
   logic MIIM_WE = 1'b0, MIIM_RE = 1'b0, start = 1'b0;
   logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, MAC_TXD = 8'h3c, REG_RDATA, rx_q;
   logic [4:0] MIIM_REG = 5'h00;
   logic [15:0] MIIM_WDATA = 16'h0000, MIIM_RDATA;
   logic [1:0] SPEED_100 = 2'b01, FULL_DUPLEX = 2'b01, MAC_TX_EN = 2'b11;
   logic [1:0] PMA_TX_EN, MAC_RX_DV, LOOP, ISO, LINE;
   wire  [1:0] XO, AN, LG, DV; // driven bit by bit by the two partners
   wire  [9:0] PA;
   wire  [7:0] PMA_RXD;
   logic [7:0] PMA_TXD, MAC_RXD;
   logic REG_RVALID, MIIM_RVALID;
   int fails = 0, n_checks = 0, i;
   logic [7:0] mode_tab [4] = '{8'h02, 8'h05, 8'h03, 8'h06}; // by {speed, full}
   always #50 CLOCK = ~CLOCK;
   always @(posedge CLOCK) rx_q <= PMA_RXD; // receive seen at last edge
   // ---------------------------------------------------------
   // design and the two link partners
   // ---------------------------------------------------------
   port_phy_status_loopback_regs DUT (.CLOCK(CLOCK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA),
      .REG_RVALID(REG_RVALID), .MIIM_PORT(MIIM_PORT), .MIIM_REG(MIIM_REG),
      .MIIM_WDATA(MIIM_WDATA), .MIIM_WE(MIIM_WE), .MIIM_RE(MIIM_RE), .MIIM_RDATA(MIIM_RDATA),
      .MIIM_RVALID(MIIM_RVALID), .PARTNER_ABILITY(PA), .CROSSOVER_STATE(XO),
      .AUTONEG_COMPLETE(AN), .LINK_GOOD(LG), .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX),
      .MAC_TXD(MAC_TXD), .MAC_TX_EN(MAC_TX_EN), .PMA_RXD(PMA_RXD), .PMA_RX_DV(DV),
      .PMA_TXD(PMA_TXD), .PMA_TX_EN(PMA_TX_EN), .MAC_RXD(MAC_RXD), .MAC_RX_DV(MAC_RX_DV),
      .MEDIUM_SIDE_LOOP_ENABLE(LOOP), .PHY_ISOLATE(ISO), .TX_LINE_EN(LINE));
   link_partner_model #(.ABILITY(5'h15), .MDI(1'b1)) lp1 (.clock(CLOCK), .reset_n(RESET_N),
      .start(start), .ability(PA[4:0]), .crossover_state(XO[0]), .autoneg_complete(AN[0]),
      .link_good(LG[0]), .rxd(PMA_RXD[3:0]), .rx_dv(DV[0]));
   link_partner_model #(.ABILITY(5'h0a), .MDI(1'b0), .SEED(4'h8)) lp2 (.clock(CLOCK),
      .reset_n(RESET_N),
      .start(start), .ability(PA[9:5]), .crossover_state(XO[1]), .autoneg_complete(AN[1]),
      .link_good(LG[1]), .rxd(PMA_RXD[7:4]), .rx_dv(DV[1]));
   // ---------------------------------------------------------
   // compare, access tasks and closing report
   // ---------------------------------------------------------
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge CLOCK); REG_ADDR = a; REG_RE = 1'b1;
      @(negedge CLOCK); REG_RE = 1'b0;
      chk("reg valid", 16'h1, {15'h0, REG_RVALID});
      chk("reg data", {8'h00, exp}, {8'h00, REG_RDATA});
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge CLOCK); REG_ADDR = a; REG_WDATA = d; REG_WE = 1'b1;
      @(negedge CLOCK); REG_WE = 1'b0;
      repeat (2) @(negedge CLOCK); // command outputs follow two edges on
   endtask
   task mx(input logic p, input logic [4:0] r, input logic w, input logic [15:0] d);
      @(negedge CLOCK); MIIM_PORT = p; MIIM_REG = r; MIIM_WDATA = d; MIIM_WE = w; MIIM_RE = !w;
      @(negedge CLOCK); MIIM_WE = 1'b0; MIIM_RE = 1'b0;
      if (w) repeat (2) @(negedge CLOCK);
      else chk("miim data", d, miim_seen());
   endtask
   function logic [15:0] miim_seen();
      return MIIM_RVALID === 1'b1 ? MIIM_RDATA : 16'hdead; // missing valid never matches
   endfunction
   task loop_data(input logic [1:0] en); // looped and monitor ports swap receive
      chk("loop enable", {14'h0, en}, {14'h0, LOOP});
      chk("tx port1", {12'h0, rx_q[7:4]}, {12'h0, PMA_TXD[3:0]});
      chk("tx port2", {12'h0, rx_q[3:0]}, {12'h0, PMA_TXD[7:4]});
      chk("rx valid", 16'h0, {14'h0, MAC_RX_DV});
   endtask
   task normal_data; // both ports straight through, no loop
      chk("loop enable", 16'h0, {14'h0, LOOP});
      chk("normal tx", {8'h00, MAC_TXD}, {8'h00, PMA_TXD});
      chk("normal rx", {8'h00, rx_q}, {8'h00, MAC_RXD});
      chk("normal rx valid", 16'h3, {14'h0, MAC_RX_DV});
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ---------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------
   initial
   begin
      repeat (12) @(negedge CLOCK);
      RESET_N = 1'b1;
      rd(8'h2e, 8'h00);
      rd(8'h2f, 8'h01);
      rd(8'h40, 8'h00); // unmapped
      start = 1'b1;
      for (i = 0; i < 100 && AN !== 2'b11; i++) @(negedge CLOCK);
      if (i == 100)
      begin
         fails++;
         report_and_stop;
      end
      rd(8'h2e, 8'hf5);
      rd(8'h3e, 8'h6a);
      for (i = 0; i < 4; i++)
      begin
         {SPEED_100[0], FULL_DUPLEX[0]} = i[1:0];
         rd(8'h2f, mode_tab[i]);
      end
      rd(8'h3f, 8'h02);
      wr(8'h2e, 8'hff);
      rd(8'h2e, 8'hf5);
      wr(8'h2f, 8'h86);
      rd(8'h2f, 8'h86);
      repeat (3) begin @(negedge CLOCK); loop_data(2'b01); end
      wr(8'h2f, 8'h00);
      normal_data;
      wr(8'h3f, 8'h80);
      loop_data(2'b10);
      wr(8'h3f, 8'ha0);
      rd(8'h3f, 8'ha2);
      chk("isolate", 16'h2, {14'h0, ISO});
      chk("line enable", 16'h1, {14'h0, LINE});
      chk("tx enable", 16'h1, {14'h0, PMA_TX_EN});
      wr(8'h3f, 8'h00);
      normal_data;
      mx(1'b0, 5'h00, 1'b1, 16'h4000);
      rd(8'h2f, 8'h86);
      mx(1'b0, 5'h00, 1'b0, 16'h4000);
      mx(1'b0, 5'h05, 1'b0, 16'h04a0);
      mx(1'b1, 5'h05, 1'b0, 16'h0140);
      mx(1'b1, 5'h01, 1'b0, 16'h0024);
      report_and_stop;
   end
endmodule // port_phy_status_loopback_regs_bench
